// file: design/rtc_timer_cfg.svh
// Function
// [RULE_01] tick select 00: sub-timer ticks at 4kHz, count steps 100Hz, default limit 41
// [RULE_02] tick select 01: sub-timer ticks at 100Hz, count steps each second, default 100
// [RULE_03] tick select 10: sub-timer ticks each second, count steps each minute, default 60
// [RULE_04] tick select 11: sub-timer ticks each minute, count steps each hour, default 60
// [RULE_05] host enables clock counting before using second or minute tick settings
// [RULE_06] host never combines 100Hz/4kHz tick setting with the watchdog function
// [RULE_07] a zero sub-timer limit means the default limit of the selected tick rate
// [RULE_08] sub-timer limit and sub-timer counter never exceed 127
// [RULE_09] sub-timer increments at tick rate; reaching its limit steps the main count
// [RULE_10] function 00 is a plain countdown, decrementing on each sub-timer overflow
// [RULE_11] function 01 is a countdown that starts once the alarm flag is set
// [RULE_12] function 10 is a watchdog counting up with a periodic interrupt
// [RULE_13] function 11 counts up only after switching to battery backup
// [RULE_14] enable bit 1 starts the timer, 0 stops it; it is 0 after power-up; the code keeps it 0 if a countdown is enabled with a limit below 2
// [RULE_15] the timer interrupt reaches the second interrupt output only when enabled
// [RULE_16] pulse mode 1: expiries recur, each gives a 210ms low pulse
// [RULE_17] pulse mode 0: single event, output held low until flag cleared; resets 0
// [RULE_18] timer limit register is read/write, resets to 0, limits the main count
// [RULE_19] timer count register is read-only and shows the present main count
// [RULE_20] sub-timer limit register is write-only; reads return zero
// [RULE_21] the sub-timer counter is internal and cannot be read or written
// [RULE_22] on expiry the timer status flag sets and the interrupt output goes low
// [RULE_23] host loads the timer limit with at least 2
// [RULE_24] on each sub-timer overflow the sub-timer counter restarts at 1
// [RULE_25] disabling returns the main count to 0 and the sub-timer counter to 1
// [RULE_26] control bits 3 and 2 read as zero and ignore writes
`ifndef RTC_TIMER_CFG_SVH
`define RTC_TIMER_CFG_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define REG_TIMER_CONTROL   8'h09
`define REG_TIMER_LIMIT     8'h12
`define REG_TIMER_COUNT     8'h13
`define REG_SUBTIMER_LIMIT  8'h14

// ****************************************************************
// control fields and reset values
// ****************************************************************
`define CTRL_PULSE_BIT      7
`define CTRL_ENABLE_BIT     6
`define CTRL_FSEL_HI        5
`define CTRL_FSEL_LO        4
`define CTRL_TSEL_HI        1
`define CTRL_TSEL_LO        0
`define RESET_CONTROL       8'h00
`define RESET_LIMIT         8'h00
`define RESET_SUB_LIMIT     7'h00

// ****************************************************************
// counting constants
// ****************************************************************
`define SUB_DEFAULT_4K      7'h29
`define SUB_DEFAULT_100HZ   7'h64
`define SUB_DEFAULT_SEC     7'h3C
`define SUB_DEFAULT_MIN     7'h3C
`define SUB_LIMIT_MAX       8'h7F
`define SUB_RESTART         7'h01
`define COUNT_IDLE          8'h00
`define COUNT_UP_START      8'h01
`define LIMIT_MIN           8'h02

// ****************************************************************
// timing
// ****************************************************************
`define CLK_MHZ             125
`define TICK_4K_PERIOD_US   244
`define TICK_100_PERIOD_MS  10
`define IRQ_PULSE_MS        210
`define TICK_4K_CYCLES      (`TICK_4K_PERIOD_US * `CLK_MHZ)
`define TICK_100_CYCLES     (`TICK_100_PERIOD_MS * 1000 * `CLK_MHZ)
`define IRQ_PULSE_CYCLES    (`IRQ_PULSE_MS * 1000 * `CLK_MHZ)

`endif

// file: design/rtc_timer_pkg.sv
package rtc_timer_pkg;

    typedef enum logic [1:0] {
        FN_COUNTDOWN,
        FN_ALARM_START,
        FN_WATCHDOG,
        FN_BACKUP_COUNT
    } function_t;

    typedef enum logic [1:0] {
        RATE_4K,
        RATE_100HZ,
        RATE_SEC,
        RATE_MIN
    } tick_rate_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMED,
        ST_RUN,
        ST_HOLD
    } timer_state_t;

endpackage : rtc_timer_pkg

// file: design/rate_divider.sv
`timescale 1ns/1ps
`default_nettype none

module rate_divider #(
    parameter int unsigned DIV = 2
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    output var  logic tick
);

    logic [31:0] count;

    if (DIV < 1) begin : g_check
        $error("rate_divider: DIV must be at least 1");
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count <= 32'h0000_0000;
            tick  <= 1'b0;
        end else if (count >= 32'(DIV - 1)) begin
            count <= 32'h0000_0000;
            tick  <= 1'b1;
        end else begin
            count <= count + 32'h0000_0001;
            tick  <= 1'b0;
        end
    end

endmodule : rate_divider

`default_nettype wire

// file: design/rtc_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "rtc_timer_cfg.svh"

module rtc_timer
    import rtc_timer_pkg::*;
#(
    parameter int unsigned TICK_4K_CYCLES   = `TICK_4K_CYCLES,
    parameter int unsigned TICK_100_CYCLES  = `TICK_100_CYCLES,
    parameter int unsigned IRQ_PULSE_CYCLES = `IRQ_PULSE_CYCLES
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output var  logic [7:0] reg_rdata,
    input  wire logic       tick_1s,
    input  wire logic       tick_1min,
    input  wire logic       alarm_status_flag,
    input  wire logic       battery_mode,
    input  wire logic       second_interrupt_enable,
    input  wire logic       timer_status_clear,
    output var  logic       timer_status_flag,
    output var  logic       second_interrupt_out_n
);

    if (TICK_4K_CYCLES < 1 || TICK_100_CYCLES < 1 || IRQ_PULSE_CYCLES < 1) begin : g_check
        $error("rtc_timer: cycle counts must be at least 1");
    end

    // named copies so that single bits and slices can be taken
    localparam logic [7:0] RESET_CTRL_VALUE = `RESET_CONTROL;
    localparam logic [7:0] SUB_LIMIT_CAP    = `SUB_LIMIT_MAX;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [6:0] eff_sub_limit(input logic [6:0] lim, input tick_rate_t sel);
        logic [6:0] dflt;
        case (sel)
            RATE_4K:    dflt = `SUB_DEFAULT_4K;
            RATE_100HZ: dflt = `SUB_DEFAULT_100HZ;
            RATE_SEC:   dflt = `SUB_DEFAULT_SEC;
            default:    dflt = `SUB_DEFAULT_MIN;
        endcase
        eff_sub_limit = (lim == 7'h00) ? dflt : lim; // RULE_07
    endfunction : eff_sub_limit

    function automatic logic counts_down(input function_t fn);
        counts_down = (fn == FN_COUNTDOWN) || (fn == FN_ALARM_START);
    endfunction : counts_down

    // ****************************************************************
    // registers and state
    // ****************************************************************
    logic         pulse_mode_bit;
    logic         timer_enable_bit;
    function_t    function_select;
    tick_rate_t   tick_rate_select;
    logic [7:0]   timer_limit;
    logic [7:0]   timer_count;
    logic [6:0]   subtimer_limit;
    logic [6:0]   subtimer_count;
    timer_state_t state;
    logic         irq_low;
    logic [31:0]  pulse_cnt;
    logic         tick_4k;
    logic         tick_100;
    logic         battery_meta;
    logic         battery_sync;
    logic         sub_tick;
    logic         sub_overflow;
    logic         step;
    logic         expire_now;
    logic         recurring;
    logic         start_cond;
    logic [7:0]   next_count;

    // ****************************************************************
    // tick sources
    // ****************************************************************
    rate_divider #(.DIV(TICK_4K_CYCLES)) u_div_4k (
        .clk_sys (clk_sys),
        .rst     (rst),
        .tick    (tick_4k)
    );

    rate_divider #(.DIV(TICK_100_CYCLES)) u_div_100 (
        .clk_sys (clk_sys),
        .rst     (rst),
        .tick    (tick_100)
    );

    // backup indication is an asynchronous pin
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            battery_meta <= 1'b0;
            battery_sync <= 1'b0;
        end else begin
            battery_meta <= battery_mode;
            battery_sync <= battery_meta;
        end
    end

    always_comb begin
        case (tick_rate_select)
            RATE_4K:    sub_tick = tick_4k;   // RULE_01
            RATE_100HZ: sub_tick = tick_100;  // RULE_02
            RATE_SEC:   sub_tick = tick_1s;   // RULE_03
            default:    sub_tick = tick_1min; // RULE_04
        endcase
    end

    assign sub_overflow = subtimer_count >= eff_sub_limit(subtimer_limit, tick_rate_select); // RULE_09
    assign step         = (state == ST_RUN) && sub_tick && sub_overflow;
    assign recurring    = pulse_mode_bit || (function_select == FN_WATCHDOG); // RULE_12
    assign next_count   = counts_down(function_select) ? timer_count - 8'h01 : timer_count + 8'h01;
    assign expire_now   = step && (counts_down(function_select) ? (next_count == 8'h00)
                                                                : (next_count >= timer_limit));
    assign start_cond   = (function_select == FN_ALARM_START) ? alarm_status_flag   // RULE_11
                                                              : battery_sync;       // RULE_13

    // ****************************************************************
    // control register
    // ****************************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pulse_mode_bit   <= RESET_CTRL_VALUE[`CTRL_PULSE_BIT];  // RULE_17
            timer_enable_bit <= RESET_CTRL_VALUE[`CTRL_ENABLE_BIT]; // RULE_14
            function_select  <= FN_COUNTDOWN;
            tick_rate_select <= RATE_4K;
        end else if (reg_write && reg_addr == `REG_TIMER_CONTROL) begin
            function_select  <= function_t'(reg_wdata[`CTRL_FSEL_HI:`CTRL_FSEL_LO]);
            tick_rate_select <= tick_rate_t'(reg_wdata[`CTRL_TSEL_HI:`CTRL_TSEL_LO]);
            // pulse mode may be raised only while stopped
            if (!timer_enable_bit || !reg_wdata[`CTRL_PULSE_BIT]) begin
                pulse_mode_bit <= reg_wdata[`CTRL_PULSE_BIT];
            end
            // a countdown with a limit below two refuses to start
            if (reg_wdata[`CTRL_ENABLE_BIT] && !timer_enable_bit
                && counts_down(function_t'(reg_wdata[`CTRL_FSEL_HI:`CTRL_FSEL_LO]))
                && timer_limit < `LIMIT_MIN) begin
                timer_enable_bit <= 1'b0;
            end else begin
                timer_enable_bit <= reg_wdata[`CTRL_ENABLE_BIT]; // RULE_14
            end
        end
    end

    // ****************************************************************
    // limit registers
    // ****************************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            timer_limit    <= `RESET_LIMIT;     // RULE_18
            subtimer_limit <= `RESET_SUB_LIMIT;
        end else if (reg_write) begin
            if (reg_addr == `REG_TIMER_LIMIT) begin
                timer_limit <= reg_wdata; // RULE_18
            end
            if (reg_addr == `REG_SUBTIMER_LIMIT) begin
                subtimer_limit <= (reg_wdata > SUB_LIMIT_CAP) ? SUB_LIMIT_CAP[6:0] : reg_wdata[6:0]; // RULE_08
            end
        end
    end

    // ****************************************************************
    // counting engine
    // ****************************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state          <= ST_IDLE;
            timer_count    <= `COUNT_IDLE;
            subtimer_count <= `SUB_RESTART;
            irq_low        <= 1'b0;
            pulse_cnt      <= 32'h0000_0000;
        end else if (!timer_enable_bit) begin
            state          <= ST_IDLE;
            timer_count    <= `COUNT_IDLE;  // RULE_25
            subtimer_count <= `SUB_RESTART; // RULE_25
            irq_low        <= 1'b0;
            pulse_cnt      <= 32'h0000_0000;
        end else if (timer_status_clear && timer_status_flag && !expire_now) begin
            // clearing the flag restarts the counting cycle
            state          <= ST_IDLE;
            subtimer_count <= `SUB_RESTART;
            irq_low        <= 1'b0;
            pulse_cnt      <= 32'h0000_0000;
        end else begin
            if (irq_low && recurring) begin
                if (pulse_cnt == 32'h0000_0000) begin
                    irq_low <= 1'b0;
                end else begin
                    pulse_cnt <= pulse_cnt - 32'h0000_0001; // RULE_16
                end
            end
            case (state)
                ST_IDLE: begin
                    timer_count    <= counts_down(function_select) ? timer_limit : `COUNT_UP_START;
                    subtimer_count <= `SUB_RESTART;
                    if (function_select == FN_ALARM_START || function_select == FN_BACKUP_COUNT) begin
                        state <= ST_ARMED;
                    end else begin
                        state <= ST_RUN;
                    end
                end
                ST_ARMED: begin
                    if (start_cond) begin
                        state <= ST_RUN; // RULE_11 RULE_13
                    end
                end
                ST_RUN: begin
                    if (sub_tick) begin
                        if (sub_overflow) begin
                            subtimer_count <= `SUB_RESTART; // RULE_24
                            if (expire_now) begin
                                irq_low <= 1'b1; // RULE_22
                                if (recurring) begin
                                    timer_count <= counts_down(function_select) ? timer_limit
                                                                                : `COUNT_UP_START;
                                    pulse_cnt   <= 32'(IRQ_PULSE_CYCLES - 1); // RULE_16
                                end else begin
                                    timer_count <= next_count;
                                    state       <= ST_HOLD; // RULE_17
                                end
                            end else begin
                                timer_count <= next_count; // RULE_09 RULE_10 RULE_12
                            end
                        end else begin
                            subtimer_count <= subtimer_count + 7'h01; // RULE_09
                        end
                    end
                end
                ST_HOLD: begin
                    irq_low <= 1'b1; // RULE_17
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // status flag and interrupt pin
    // ****************************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            timer_status_flag <= 1'b0;
        end else if (expire_now) begin
            timer_status_flag <= 1'b1; // RULE_22
        end else if (timer_status_clear) begin
            timer_status_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            second_interrupt_out_n <= 1'b1;
        end else begin
            second_interrupt_out_n <= !(irq_low && second_interrupt_enable); // RULE_15
        end
    end

    // ****************************************************************
    // register reads
    // ****************************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                `REG_TIMER_CONTROL:  reg_rdata <= {pulse_mode_bit, timer_enable_bit, function_select,
                                                   2'b00, tick_rate_select}; // RULE_26
                `REG_TIMER_LIMIT:    reg_rdata <= timer_limit;
                `REG_TIMER_COUNT:    reg_rdata <= timer_count; // RULE_19
                `REG_SUBTIMER_LIMIT: reg_rdata <= 8'h00;       // RULE_20 RULE_21
                default:             reg_rdata <= 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    a_disable_reset: assert property (@(posedge clk_sys) disable iff (rst) // RULE_25
        !timer_enable_bit |=> (timer_count == 8'h00 && subtimer_count == 7'h01))
        else $error("counters not returned to idle values while disabled");

    a_sub_bound: assert property (@(posedge clk_sys) disable iff (rst) // RULE_08
        subtimer_count <= 7'h7F && subtimer_count <= eff_sub_limit(subtimer_limit, tick_rate_select)
        || state != ST_RUN)
        else $error("sub-timer counter exceeds its limit");

    a_sub_restart: assert property (@(posedge clk_sys) disable iff (rst) // RULE_24
        (step && timer_enable_bit && !timer_status_clear) |=> subtimer_count == 7'h01)
        else $error("sub-timer did not restart at one on overflow");

    a_countdown_step: assert property (@(posedge clk_sys) disable iff (rst) // RULE_10
        (step && !expire_now && timer_enable_bit && !timer_status_clear && counts_down(function_select))
        |=> timer_count == $past(timer_count) - 8'h01)
        else $error("countdown did not decrement by one");

    a_flag_expiry: assert property (@(posedge clk_sys) disable iff (rst) // RULE_22
        expire_now |=> timer_status_flag ##1 (timer_status_flag || $past(timer_status_clear)))
        else $error("status flag not set on expiry");

    a_irq_gated: assert property (@(posedge clk_sys) disable iff (rst) // RULE_15
        !second_interrupt_enable |=> second_interrupt_out_n)
        else $error("interrupt output low while its enable is off");

    a_hold_low: assert property (@(posedge clk_sys) disable iff (rst) // RULE_17
        (state == ST_HOLD && timer_enable_bit && second_interrupt_enable && !timer_status_clear)
        |=> !second_interrupt_out_n)
        else $error("single event interrupt released before flag clear");

    a_pulse_width: assert property (@(posedge clk_sys) disable iff (rst) // RULE_16
        (expire_now && recurring && timer_enable_bit) |=> (irq_low && pulse_cnt == 32'(IRQ_PULSE_CYCLES - 1)))
        else $error("pulse interval not started on recurring expiry");

    a_sub_readback: assert property (@(posedge clk_sys) disable iff (rst) // RULE_20
        (reg_read && reg_addr == `REG_SUBTIMER_LIMIT) |=> reg_rdata == 8'h00)
        else $error("sub-timer limit read returned nonzero");

    a_ctrl_reserved: assert property (@(posedge clk_sys) disable iff (rst) // RULE_26
        (reg_read && reg_addr == `REG_TIMER_CONTROL) |=> reg_rdata[3:2] == 2'b00)
        else $error("reserved control bits read nonzero");

    a_enable_refused: assert property (@(posedge clk_sys) disable iff (rst) // RULE_14
        (reg_write && reg_addr == `REG_TIMER_CONTROL && reg_wdata[`CTRL_ENABLE_BIT] && !timer_enable_bit
         && counts_down(function_t'(reg_wdata[`CTRL_FSEL_HI:`CTRL_FSEL_LO])) && timer_limit < `LIMIT_MIN)
        |=> !timer_enable_bit)
        else $error("countdown started with a limit below two");

    a_pulse_locked: assert property (@(posedge clk_sys) disable iff (rst) // RULE_16
        (timer_enable_bit && !pulse_mode_bit) |=> !pulse_mode_bit)
        else $error("pulse mode raised while the timer runs");

    a_count_readback: assert property (@(posedge clk_sys) disable iff (rst) // RULE_19
        (reg_read && reg_addr == `REG_TIMER_COUNT) |=> reg_rdata == $past(timer_count))
        else $error("count read does not show the main count");

endmodule : rtc_timer

`default_nettype wire

// file: tb/tod_ticks.sv
`timescale 1ns/1ps
`default_nettype none
module tod_ticks #(
    parameter int SEC = 6,
    parameter int MIN = 4
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    output var  logic tick_1s,
    output var  logic tick_1min
);
    int cyc;
    int secs;
    // ****************************************************************
    // time-of-day tick source, counting from reset onwards
    // ****************************************************************
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cyc       <= 0;
            secs      <= 0;
            tick_1s   <= 1'b0;
            tick_1min <= 1'b0;
        end else begin
            tick_1s   <= (cyc == SEC - 1);
            tick_1min <= (cyc == SEC - 1) && (secs == MIN - 1);
            cyc       <= (cyc == SEC - 1) ? 0 : cyc + 1;
            if (cyc == SEC - 1) begin
                secs <= (secs == MIN - 1) ? 0 : secs + 1;
            end
        end
    end
endmodule : tod_ticks
`default_nettype wire

// file: tb/test_rtc_timer.sv
`timescale 1ns/1ps
`default_nettype none
module test_rtc_timer;
    import rtc_timer_pkg::*;
    logic       clk_sys = 0, rst = 1, reg_write = 0, reg_read = 0, alarm_status_flag = 0;
    logic       battery_mode = 0, second_interrupt_enable = 1, timer_status_clear = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rv;
    wire logic [7:0] reg_rdata;
    wire logic  tick_1s, tick_1min, timer_status_flag, second_interrupt_out_n;
    int         errors = 0, samples_checked = 0, n, w, lim, sub, per;
    logic [7:0] addrs [5] = '{8'h09, 8'h12, 8'h13, 8'h14, 8'h20};
    rtc_timer #(.TICK_4K_CYCLES(4), .TICK_100_CYCLES(8), .IRQ_PULSE_CYCLES(10)) dut (.clk_sys, .rst,
        .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .tick_1s, .tick_1min,
        .alarm_status_flag, .battery_mode, .second_interrupt_enable, .timer_status_clear,
        .timer_status_flag, .second_interrupt_out_n);
    tod_ticks #(.SEC(6), .MIN(4)) tod (.clk_sys, .rst, .tick_1s, .tick_1min);
    // ****************************************************************
    // helpers
    // ****************************************************************
    initial forever #4 clk_sys = ~clk_sys;
    function automatic int dsub(input int s, input int v);
        return (v != 0) ? v : (s == 0) ? 41 : (s == 1) ? 100 : 60;
    endfunction : dsub
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic step(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        step(1);
        reg_write = 1'b0;
        step(1);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        reg_addr = a;
        reg_read = 1'b1;
        step(1);
        reg_read = 1'b0;
        step(1);
        rv = reg_rdata;
    endtask : rd
    task automatic wait_flag();
        n = 0;
        while (timer_status_flag !== 1'b1 && n < 20000) begin
            step(1);
            n++;
        end
        chk("flag_wait", 16'(n < 20000), 16'h0001);
    endtask : wait_flag
    task automatic clear_flag();
        timer_status_clear = 1'b1;
        step(1);
        timer_status_clear = 1'b0;
        step(2);
    endtask : clear_flag
    task automatic pulse_len();
        step(1);
        w = 0;
        while (second_interrupt_out_n === 1'b0 && w < 100) begin
            step(1);
            w++;
        end
    endtask : pulse_len
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    initial begin
        #(8 * 60000);
        errors++;
        tally_and_finish();
    end
    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        void'($urandom(23109));
        step(5);
        rst = 1'b0;
        foreach (addrs[i]) begin
            rd(addrs[i]);
            chk("reset_value", 16'(rv), 16'h0000);
        end
        wr(8'h09, 8'h0C);
        rd(8'h09);
        chk("ctrl_reserved", 16'(rv), 16'h0000);
        lim = 2 + $urandom % 250;
        wr(8'h12, 8'(lim));
        rd(8'h12);
        chk("timer_limit", 16'(rv), 16'(lim));
        wr(8'h13, 8'hA5);
        rd(8'h13);
        chk("count_ro", 16'(rv), 16'h0000);
        wr(8'h14, 8'h05);
        rd(8'h14);
        chk("sub_limit_wo", 16'(rv), 16'h0000);
        $display("test registers done");
        for (int s = 0; s < 4; s++) begin
            lim = 2 + $urandom % 6;
            sub = ($urandom % 3 == 0) ? 0 : 2 + $urandom % 6;
            per = (s == 0) ? 4 : (s == 1) ? 8 : (s == 2) ? 6 : 24;
            second_interrupt_enable = (s != 1);
            wr(8'h12, 8'(lim));
            wr(8'h14, 8'(sub));
            wr(8'h09, 8'h40 | 8'(s));
            wait_flag();
            sub = dsub(s, sub);
            w = int'(n >= lim * (sub - 1) * per - 2 * per && n <= (lim * (sub + 1) + 2) * per);
            chk("expiry_time", 16'(w), 16'h0001);
            rd(8'h13);
            chk("count_at_expiry", 16'(rv), 16'h0000);
            chk("irq_low", 16'(second_interrupt_out_n), 16'(s == 1));
            clear_flag();
            chk("irq_released", 16'({timer_status_flag, second_interrupt_out_n}), 16'h0001);
            wr(8'h09, 8'h00);
            rd(8'h13);
            chk("count_disabled", 16'(rv), 16'h0000);
        end
        second_interrupt_enable = 1'b1;
        $display("test countdown rates done");
        wr(8'h12, 8'h03);
        wr(8'h14, 8'h02);
        wr(8'h09, 8'h50);
        step(60);
        rd(8'h13);
        chk("alarm_wait", 16'({timer_status_flag, rv}), 16'h0003);
        alarm_status_flag = 1'b1;
        wait_flag();
        alarm_status_flag = 1'b0;
        wr(8'h09, 8'h00);
        clear_flag();
        $display("test alarm start done");
        wr(8'h12, 8'h01);
        wr(8'h09, 8'h40);
        rd(8'h09);
        chk("enable_refused", 16'(rv), 16'h0000);
        wr(8'h12, 8'h03);
        wr(8'h09, 8'h41);
        wr(8'h09, 8'hC1);
        rd(8'h09);
        chk("pulse_locked", 16'(rv), 16'h0041);
        wr(8'h09, 8'h00);
        wr(8'h09, 8'hC1);
        wait_flag();
        pulse_len();
        chk("pulse_width", 16'(w), 16'h000A);
        w = 0;
        while (second_interrupt_out_n === 1'b1 && w < 200) begin
            step(1);
            w++;
        end
        chk("pulse_recurs", 16'(w < 200), 16'h0001);
        wr(8'h09, 8'h00);
        clear_flag();
        $display("test pulse countdown done");
        wr(8'h09, 8'h61);
        for (int k = 0; k < 2; k++) begin
            wait_flag();
            pulse_len();
            chk("pulse_width", 16'(w), 16'h000A);
            clear_flag();
        end
        wr(8'h09, 8'h00);
        $display("test watchdog done");
        wr(8'h09, 8'h73);
        step(100);
        rd(8'h13);
        chk("backup_wait", 16'({timer_status_flag, rv}), 16'h0001);
        battery_mode = 1'b1;
        wait_flag();
        wr(8'h09, 8'h00);
        $display("test backup count done");
        tally_and_finish();
    end
endmodule : test_rtc_timer
`default_nettype wire
